// File: verilog/thermal_filter_pkg.sv
package thermal_filter_pkg;

    // ==========================================================
    // register offsets
    localparam logic [15:0] RELATIVE_TEMPERATURE_OFS   = 16'h1048;
    localparam logic [15:0] INTEGRATOR_CONTROL_OFS     = 16'h104B;
    localparam logic [15:0] MOVING_AVERAGE_CONTROL_OFS = 16'h104C;
    localparam logic [15:0] MOVING_AVERAGE_VALUE_OFS   = 16'h104D;

    // ==========================================================
    // reset values
    localparam logic [7:0] RELATIVE_TEMPERATURE_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST              = 8'h00;
    localparam logic [7:0] FILTER_OUT_RST           = 8'h00;

    // ==========================================================
    // control field positions
    localparam int CFG_LOCK_BIT     = 7;
    localparam int SAMPLES_DONE_BIT = 6;
    localparam int INT_TEST_BIT     = 5;
    localparam int AVG_TEST_BIT     = 4;
    localparam int INTERVAL_LSB     = 0;
    localparam int INTERVAL_W       = 3;

    // ==========================================================
    // filter shift figures
    localparam int          FRAC_W      = 27;
    localparam int          ACC_W       = 8 + FRAC_W;
    localparam int          CNT_W       = 28;
    localparam logic [4:0]  INT_TEST_P  = 5'h07;
    localparam logic [4:0]  AVG_TEST_P  = 5'h1B;
    localparam logic [4:0]  INT_P_BASE  = 5'h04;
    localparam logic [4:0]  INT_P_MAX   = 5'h0E;
    localparam logic [4:0]  AVG_P_MAX   = 5'h06;
    localparam logic [2:0]  INT_CODE_MAX = 3'h5;
    localparam logic [2:0]  AVG_CODE_MAX = 3'h3;
    localparam logic signed [8:0] REL_MAX = 9'sh07F;
    localparam logic signed [8:0] REL_MIN = -9'sh080;

    // ==========================================================
    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_s;

endpackage : thermal_filter_pkg

// File: verilog/thermal_reading_filters.sv
`timescale 1ns/1ps
module thermal_reading_filters (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    // register port
    input  wire thermal_filter_pkg::reg_req_s i_reg_req,
    output logic [7:0]                     o_reg_rdata,
    output logic                           o_reg_rvalid,
    // sensor side
    input  wire logic [7:0]                i_raw_reading,
    input  wire logic                      i_sample_toggle,
    // configuration from neighbouring logic
    input  wire logic [7:0]                i_reading_offset,
    input  wire logic                      i_thermometer_mode
);

    // ==========================================================
    // sensor synchronisers
    logic [7:0] raw_s1_reg;
    logic [7:0] raw_s2_reg;
    logic       tog_s1_reg;
    logic       tog_s2_reg;
    logic       tog_s3_reg;
    logic       sample_stb;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            raw_s1_reg <= 8'h00;
            raw_s2_reg <= 8'h00;
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else begin
            raw_s1_reg <= i_raw_reading;
            raw_s2_reg <= raw_s1_reg;
            tog_s1_reg <= i_sample_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    assign sample_stb = tog_s2_reg ^ tog_s3_reg;

    // ==========================================================
    // control registers
    logic       int_lock_reg;
    logic       int_test_reg;
    logic [2:0] int_interval_reg;
    logic       avg_lock_reg;
    logic       avg_test_reg;
    logic [2:0] avg_interval_reg;
    logic       wr_int;
    logic       wr_avg;

    assign wr_int = i_reg_req.wr && (i_reg_req.addr == thermal_filter_pkg::INTEGRATOR_CONTROL_OFS);
    assign wr_avg = i_reg_req.wr
                    && (i_reg_req.addr == thermal_filter_pkg::MOVING_AVERAGE_CONTROL_OFS);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_lock_reg     <= thermal_filter_pkg::CONTROL_RST[thermal_filter_pkg::CFG_LOCK_BIT];
            int_test_reg     <= thermal_filter_pkg::CONTROL_RST[thermal_filter_pkg::INT_TEST_BIT];
            int_interval_reg <= thermal_filter_pkg::CONTROL_RST[2:0];
        end else if (wr_int && !int_lock_reg) begin
            int_lock_reg     <= i_reg_req.wdata[thermal_filter_pkg::CFG_LOCK_BIT];
            int_test_reg     <= i_reg_req.wdata[thermal_filter_pkg::INT_TEST_BIT];
            int_interval_reg <= i_reg_req.wdata[thermal_filter_pkg::INTERVAL_LSB +: 3];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            avg_lock_reg     <= thermal_filter_pkg::CONTROL_RST[thermal_filter_pkg::CFG_LOCK_BIT];
            avg_test_reg     <= thermal_filter_pkg::CONTROL_RST[thermal_filter_pkg::AVG_TEST_BIT];
            avg_interval_reg <= thermal_filter_pkg::CONTROL_RST[2:0];
        end else if (wr_avg && !avg_lock_reg) begin
            avg_lock_reg     <= i_reg_req.wdata[thermal_filter_pkg::CFG_LOCK_BIT];
            avg_test_reg     <= i_reg_req.wdata[thermal_filter_pkg::AVG_TEST_BIT];
            avg_interval_reg <= i_reg_req.wdata[thermal_filter_pkg::INTERVAL_LSB +: 3];
        end
    end

    // ==========================================================
    // shift selection, index 0 integrator, 1 moving average
    logic [4:0] p_sel [2];

    always_comb begin
        if (int_test_reg) begin
            p_sel[0] = thermal_filter_pkg::INT_TEST_P;
        end else if (int_interval_reg > thermal_filter_pkg::INT_CODE_MAX) begin
            p_sel[0] = thermal_filter_pkg::INT_P_MAX;
        end else begin
            p_sel[0] = thermal_filter_pkg::INT_P_BASE + {1'b0, int_interval_reg, 1'b0};
        end
        if (avg_test_reg) begin
            p_sel[1] = thermal_filter_pkg::AVG_TEST_P;
        end else if (avg_interval_reg > thermal_filter_pkg::AVG_CODE_MAX) begin
            p_sel[1] = thermal_filter_pkg::AVG_P_MAX;
        end else begin
            p_sel[1] = {1'b0, avg_interval_reg, 1'b0};
        end
    end

    // ==========================================================
    // recursive filters
    logic [thermal_filter_pkg::ACC_W-1:0] acc_reg [2];
    logic [thermal_filter_pkg::CNT_W-1:0] cnt_reg [2];
    logic [4:0]                           p_prev_reg [2];
    logic                                 restart_reg [2];
    logic                                 done_reg [2];
    logic [7:0]                           filt_out [2];

    for (genvar g = 0; g < 2; g++) begin : g_filter
        logic signed [thermal_filter_pkg::ACC_W:0] diff;
        logic signed [thermal_filter_pkg::ACC_W:0] step;
        logic [thermal_filter_pkg::CNT_W-1:0]      need;

        assign diff = $signed({1'b0, raw_s2_reg, {thermal_filter_pkg::FRAC_W{1'b0}}})
                      - $signed({1'b0, acc_reg[g]});
        assign step = diff >>> p_sel[g];
        assign need = {{(thermal_filter_pkg::CNT_W-1){1'b0}}, 1'b1} << p_sel[g];
        assign filt_out[g] = acc_reg[g][thermal_filter_pkg::ACC_W-1 -: 8];

        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                acc_reg[g]     <= '0;
                cnt_reg[g]     <= '0;
                p_prev_reg[g]  <= 5'h00;
                restart_reg[g] <= 1'b1;
                done_reg[g]    <= 1'b0;
            end else begin
                p_prev_reg[g] <= p_sel[g];
                if (p_prev_reg[g] != p_sel[g]) begin
                    restart_reg[g] <= 1'b1;
                    done_reg[g]    <= 1'b0;
                    cnt_reg[g]     <= '0;
                end else if (sample_stb && restart_reg[g]) begin
                    acc_reg[g]     <= {raw_s2_reg, {thermal_filter_pkg::FRAC_W{1'b0}}};
                    cnt_reg[g]     <= {{(thermal_filter_pkg::CNT_W-1){1'b0}}, 1'b1};
                    done_reg[g]    <= (p_sel[g] == 5'h00);
                    restart_reg[g] <= 1'b0;
                end else if (sample_stb) begin
                    acc_reg[g] <= acc_reg[g] + step[thermal_filter_pkg::ACC_W-1:0];
                    if (cnt_reg[g] < need) begin
                        cnt_reg[g] <= cnt_reg[g] + 1'b1;
                    end
                    if (cnt_reg[g] + 1'b1 >= need) begin
                        done_reg[g] <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // relative reading
    logic [7:0]        relative_reading_reg;
    logic signed [8:0] rel_diff;

    assign rel_diff = $signed({1'b0, raw_s2_reg}) - $signed({1'b0, i_reading_offset});

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            relative_reading_reg <= thermal_filter_pkg::RELATIVE_TEMPERATURE_RST;
        end else if (sample_stb && i_thermometer_mode) begin
            if (rel_diff > thermal_filter_pkg::REL_MAX) begin
                relative_reading_reg <= thermal_filter_pkg::REL_MAX[7:0];
            end else if (rel_diff < thermal_filter_pkg::REL_MIN) begin
                relative_reading_reg <= thermal_filter_pkg::REL_MIN[7:0];
            end else begin
                relative_reading_reg <= rel_diff[7:0];
            end
        end
    end

    // ==========================================================
    // register readback
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_req.rd;
            o_reg_rdata  <= 8'h00;
            if (i_reg_req.rd) begin
                unique case (i_reg_req.addr)
                    thermal_filter_pkg::RELATIVE_TEMPERATURE_OFS: begin
                        o_reg_rdata <= relative_reading_reg;
                    end
                    thermal_filter_pkg::INTEGRATOR_CONTROL_OFS: begin
                        o_reg_rdata <= {int_lock_reg, done_reg[0], int_test_reg,
                                        2'b00, int_interval_reg};
                    end
                    thermal_filter_pkg::MOVING_AVERAGE_CONTROL_OFS: begin
                        o_reg_rdata <= {avg_lock_reg, done_reg[1], 1'b0, avg_test_reg,
                                        1'b0, avg_interval_reg};
                    end
                    thermal_filter_pkg::MOVING_AVERAGE_VALUE_OFS: begin
                        o_reg_rdata <= filt_out[1];
                    end
                    default: begin
                        o_reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

endmodule : thermal_reading_filters

// File: bench/thermal_reading_filters_assertions.sv
`timescale 1ns/1ps
module thermal_reading_filters_assertions (
    // clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    // register port
    input  wire thermal_filter_pkg::reg_req_s i_reg_req,
    input  wire logic [7:0]                   o_reg_rdata,
    input  wire logic                         o_reg_rvalid,
    // sensor and neighbours
    input  wire logic [7:0]                   i_raw_reading,
    input  wire logic                         i_sample_toggle,
    input  wire logic [7:0]                   i_reading_offset,
    input  wire logic                         i_thermometer_mode
);
    // ==========================================================
    // shadows of the writable control fields
    logic [7:0] int_cfg_reg;
    logic [7:0] avg_cfg_reg;
    logic       tog_reg;
    logic       sampled_reg;
    logic       rd_int;
    logic       rd_avg;
    assign rd_int = i_reg_req.rd && i_reg_req.addr == 16'h104B;
    assign rd_avg = i_reg_req.rd && i_reg_req.addr == 16'h104C;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_cfg_reg <= 8'h00;
            avg_cfg_reg <= 8'h00;
        end else if (i_reg_req.wr) begin
            if (i_reg_req.addr == 16'h104B && !int_cfg_reg[7])
                int_cfg_reg <= i_reg_req.wdata & 8'hA7;
            if (i_reg_req.addr == 16'h104C && !avg_cfg_reg[7])
                avg_cfg_reg <= i_reg_req.wdata & 8'h97;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_reg     <= 1'b0;
            sampled_reg <= 1'b0;
        end else begin
            tog_reg     <= i_sample_toggle;
            sampled_reg <= sampled_reg || (tog_reg != i_sample_toggle);
        end
    end
    // ==========================================================
    // expected relative reading, taken when the toggle moves
    logic signed [8:0] rel_calc;
    logic [7:0]        rel_exp_reg;
    assign rel_calc = $signed({1'b0, i_raw_reading}) - $signed({1'b0, i_reading_offset});
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rel_exp_reg <= 8'h00;
        end else if (tog_reg != i_sample_toggle && i_thermometer_mode) begin
            if (rel_calc > 9'sh07F) begin
                rel_exp_reg <= 8'h7F;
            end else if (rel_calc < -9'sh080) begin
                rel_exp_reg <= 8'h80;
            end else begin
                rel_exp_reg <= rel_calc[7:0];
            end
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rd_answer; i_reg_req.rd |=> o_reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_idle; !i_reg_req.rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("answer without read");
    property p_unmapped; i_reg_req.rd && !(i_reg_req.addr inside {16'h1048, 16'h104B,
        16'h104C, 16'h104D}) |=> o_reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_int_cfg; rd_int |=> (o_reg_rdata & 8'hA7) == $past(int_cfg_reg); endproperty
    a_int_cfg: assert property (p_int_cfg) else $error("integrator control wrong");
    property p_avg_cfg; rd_avg |=> (o_reg_rdata & 8'h97) == $past(avg_cfg_reg); endproperty
    a_avg_cfg: assert property (p_avg_cfg) else $error("average control wrong");
    property p_int_rsvd; rd_int |=> o_reg_rdata[4:3] == 2'h0; endproperty
    a_int_rsvd: assert property (p_int_rsvd) else $error("integrator reserved set");
    property p_avg_rsvd; rd_avg |=> !o_reg_rdata[5] && !o_reg_rdata[3]; endproperty
    a_avg_rsvd: assert property (p_avg_rsvd) else $error("average reserved set");
    property p_done_idle; (rd_int || rd_avg) && !sampled_reg |=> !o_reg_rdata[6]; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done without samples");
    property p_rel_read; i_reg_req.rd && i_reg_req.addr == 16'h1048
        |=> o_reg_rdata == $past(rel_exp_reg); endproperty
    a_rel_read: assert property (p_rel_read) else $error("relative reading wrong");
endmodule : thermal_reading_filters_assertions
bind thermal_reading_filters thermal_reading_filters_assertions chk_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_raw_reading(i_raw_reading),
    .i_sample_toggle(i_sample_toggle), .i_reading_offset(i_reading_offset),
    .i_thermometer_mode(i_thermometer_mode));

// File: bench/thermal_sensor_model.sv
`timescale 1ns/1ps
module thermal_sensor_model (
    // clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // sample link
    output logic [7:0] o_raw_reading,
    output logic       o_sample_toggle
);
    initial o_raw_reading = 8'h00;
    initial o_sample_toggle = 1'b0;
    always @(posedge i_rst) o_sample_toggle = 1'b0;
    // unsigned byte, steady around the toggle, scrambled afterwards
    task automatic send(input logic [7:0] v);
        @(posedge i_clk) #1 o_raw_reading = v;
        @(posedge i_clk) #1 o_sample_toggle = ~o_sample_toggle;
        repeat (4) @(posedge i_clk);
        #1 o_raw_reading = ~v;
        repeat (2) @(posedge i_clk);
    endtask : send
endmodule : thermal_sensor_model

// File: bench/thermal_reading_filters_tb.sv
`timescale 1ns/1ps
module thermal_reading_filters_tb;
    logic                         i_clk;
    logic                         i_rst;
    thermal_filter_pkg::reg_req_s req;
    logic [7:0]                   rdata;
    logic                         rvalid;
    logic [7:0]                   raw;
    logic                         tog;
    logic [7:0]                   offset;
    logic                         mode;
    int                           n_mismatch = 0;
    int                           checked = 0;
    logic [23:0] rows [7] = '{24'h501040, 24'hFF007F, 24'h00FF80, 24'h1020F0,
                              24'h7F007F, 24'h80007F, 24'hC0407F};
    logic [15:0] addrs [5] = '{16'h1048, 16'h104B, 16'h104C, 16'h104D, 16'h1049};
    always #20 i_clk = ~i_clk;
    thermal_sensor_model sensor_u (.i_clk(i_clk), .i_rst(i_rst), .o_raw_reading(raw),
        .o_sample_toggle(tog));
    thermal_reading_filters dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_reg_req(req),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_raw_reading(raw),
        .i_sample_toggle(tog), .i_reading_offset(offset), .i_thermometer_mode(mode));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk) #1 req.wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk) #1 req.rd = 1'b0;
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
    endtask : rd_chk
    task automatic complete_run;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        i_clk  = 1'b0;
        i_rst  = 1'b1;
        req    = '0;
        offset = 8'h00;
        mode   = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 i_rst = 1'b0;
        foreach (rows[i]) begin
            offset = rows[i][15:8];
            sensor_u.send(rows[i][23:16]);
            rd_chk(16'h1048, rows[i][7:0]);
            rd_chk(16'h104D, rows[i][23:16]);
        end
        // relative reading frozen outside thermometer mode
        mode = 1'b0;
        sensor_u.send(8'h20);
        rd_chk(16'h1048, 8'h7F);
        rd_chk(16'h104D, 8'h20);
        mode = 1'b1;
        rd_chk(16'h104C, 8'h40);
        // reserved codes read back as written, average test mode
        wr(16'h104B, 8'h07);
        rd_chk(16'h104B, 8'h07);
        wr(16'h104C, 8'h16);
        rd_chk(16'h104C, 8'h16);
        sensor_u.send(8'h00);
        sensor_u.send(8'h80);
        rd_chk(16'h104D, 8'h00);
        // mid-run reset
        @(posedge i_clk) #1 i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 i_rst = 1'b0;
        foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
        // integrator done after 2^4 samples
        repeat (15) sensor_u.send(8'h30);
        rd_chk(16'h104B, 8'h00);
        sensor_u.send(8'h30);
        rd_chk(16'h104B, 8'h40);
        // lock with test mode, later writes ignored, done after 2^7
        wr(16'h104B, 8'hA0);
        wr(16'h104B, 8'h01);
        rd_chk(16'h104B, 8'hA0);
        repeat (127) sensor_u.send(8'h30);
        rd_chk(16'h104B, 8'hA0);
        sensor_u.send(8'h30);
        rd_chk(16'h104B, 8'hE0);
        // restart and weighting per average code
        for (int c = 1; c < 4; c++) begin
            wr(16'h104C, 8'(c));
            sensor_u.send(8'h00);
            sensor_u.send(8'h80);
            rd_chk(16'h104D, 8'h80 >> (2 * c));
        end
        wr(16'h104C, 8'h81);
        wr(16'h104C, 8'h03);
        rd_chk(16'h104C, 8'h81);
        complete_run;
    end
    initial begin
        #(40 * 20000);
        n_mismatch++;
        complete_run;
    end
endmodule : thermal_reading_filters_tb
